// File: hdl/processor_sideband_control.sv
// Summary of operation
// - power-good pin floats during resume reset, driven with primary_power_ok_in after it.
// - power-good high tells the processor primary power is stable.
// - overheat trip input, once through the two-stage synchroniser, forces platform into S5 from any state.
// - sync output warns processor before a global reset proceeds.
// - processor wake input is treated as a wake source.
// - active-low platform reset low in reset, high after, off in deep sleep.
// - four thermal sensor inputs, never driven by this block.
// - single-wire thermal bus shared, undriven during reset and for one cycle after.
`timescale 1ns/100ps
module processor_sideband_control (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic primary_power_ok_in,
	input wire logic global_reset_req_in,
	input wire logic deep_sleep_in,
	input wire logic overheat_trip_in_n,
	input wire logic cpu_wake_event_in,
	input wire logic [3:0] thermal_sensor_in,
	input wire logic thermal_single_wire_bus_in,
	input wire logic thermal_bus_tx_en_in,
	input wire logic thermal_bus_tx_bit_in,
	output logic cpu_power_good_out,
	output logic cpu_power_good_oe_n_out,
	output logic cpu_platform_reset_n_out,
	output logic cpu_platform_reset_oe_n_out,
	output logic pwr_mgmt_sync_out,
	output logic thermal_single_wire_bus_out,
	output logic thermal_single_wire_bus_oe_n_out,
	output logic [1:0] pwr_state_out,
	output logic global_reset_go_out,
	output logic wake_seen_out,
	output logic overheat_seen_out,
	output logic thermal_bus_rx_out,
	output logic [3:0] thermal_sensor_out
);

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	sideband_pkg::side_in_t raw_in;
	sideband_pkg::side_in_t sync_in;

	always_comb begin
		raw_in.overheat = ~overheat_trip_in_n;
		raw_in.wake = cpu_wake_event_in;
		raw_in.sensor = thermal_sensor_in;
	end

	sync2 #(.W(2 + sideband_pkg::SENSOR_W)) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.d_in(raw_in),
		.q_out(sync_in)
	);

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	sideband_pkg::pwr_state_t state_r;
	sideband_pkg::pwr_state_t state_nxt;
	logic [7:0] warn_cnt_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sideband_pkg::ST_OFF: begin
				if (primary_power_ok_in && !sync_in.overheat) begin
					state_nxt = sideband_pkg::ST_ON;
				end
			end
			sideband_pkg::ST_ON: begin
				if (global_reset_req_in) begin
					state_nxt = sideband_pkg::ST_WARN;
				end
			end
			sideband_pkg::ST_WARN: begin
				if (warn_cnt_r == sideband_pkg::CNT_ZERO) begin
					state_nxt = sideband_pkg::ST_S5;
				end
			end
			sideband_pkg::ST_S5: begin
				if (sync_in.wake && !sync_in.overheat) begin
					state_nxt = sideband_pkg::ST_ON;
				end
			end
		endcase
		// overheat preempts everything, no qualification
		if (sync_in.overheat) begin
			state_nxt = sideband_pkg::ST_S5;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= sideband_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// warning lead counter
	// ----------------------------------------
	// reloads outside WARN, so each warning runs the full lead unless an overheat trip ends it early
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			warn_cnt_r <= sideband_pkg::CNT_ZERO;
		end else if (state_r != sideband_pkg::ST_WARN) begin
			warn_cnt_r <= sideband_pkg::WARN_LEAD_CNT - 8'h01;
		end else if (warn_cnt_r != sideband_pkg::CNT_ZERO) begin
			warn_cnt_r <= warn_cnt_r - 8'h01;
		end
	end

	// ----------------------------------------
	// sideband outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cpu_power_good_out <= 1'b0;
			cpu_power_good_oe_n_out <= sideband_pkg::RST_OE_N;
		end else begin
			cpu_power_good_out <= primary_power_ok_in;
			cpu_power_good_oe_n_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// platform reset
	// ----------------------------------------
	sideband_pkg::pin_drive_t plt_nxt;

	// off in deep sleep: buffer released rather than driven low
	always_comb begin
		plt_nxt.out = 1'b1;
		plt_nxt.oe_n = deep_sleep_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cpu_platform_reset_n_out <= sideband_pkg::RST_PLTRST_N;
			cpu_platform_reset_oe_n_out <= 1'b0;
		end else begin
			cpu_platform_reset_n_out <= plt_nxt.out;
			cpu_platform_reset_oe_n_out <= plt_nxt.oe_n;
		end
	end

	// ----------------------------------------
	// power-management sync
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pwr_mgmt_sync_out <= sideband_pkg::RST_SYNC;
			global_reset_go_out <= 1'b0;
		end else begin
			pwr_mgmt_sync_out <= (state_nxt == sideband_pkg::ST_WARN);
			// reset proceeds only after the warning lead has run out
			global_reset_go_out <= (state_r == sideband_pkg::ST_WARN) &&
				(state_nxt == sideband_pkg::ST_S5) && !sync_in.overheat;
		end
	end

	// ----------------------------------------
	// thermal bus and sensors
	// ----------------------------------------
	logic bus_live_r;
	sideband_pkg::pin_drive_t bus_nxt;

	// the hub only drives the wire outside S5 and deep sleep
	always_comb begin
		bus_nxt.out = thermal_bus_tx_bit_in;
		bus_nxt.oe_n = !(bus_live_r && thermal_bus_tx_en_in &&
			state_r != sideband_pkg::ST_S5 && !deep_sleep_in);
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			bus_live_r <= 1'b0;
			thermal_single_wire_bus_out <= 1'b0;
			thermal_single_wire_bus_oe_n_out <= sideband_pkg::RST_OE_N;
		end else begin
			// one cycle of release after reset keeps it undriven
			bus_live_r <= 1'b1;
			thermal_single_wire_bus_out <= bus_nxt.out;
			thermal_single_wire_bus_oe_n_out <= bus_nxt.oe_n;
		end
	end

	// level on the wire, whoever drives it; a released wire has no pull
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			thermal_bus_rx_out <= 1'b0;
		end else begin
			thermal_bus_rx_out <= thermal_single_wire_bus_in;
		end
	end

	// ----------------------------------------
	// thermal sensors and status copies
	// ----------------------------------------
	// sensors are input only; no driver exists for them
	for (genvar i = 0; i < sideband_pkg::SENSOR_W; i++) begin : g_sensor
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				thermal_sensor_out[i] <= 1'b0;
			end else begin
				thermal_sensor_out[i] <= sync_in.sensor[i];
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wake_seen_out <= 1'b0;
			overheat_seen_out <= 1'b0;
			pwr_state_out <= sideband_pkg::ST_OFF;
		end else begin
			wake_seen_out <= sync_in.wake;
			overheat_seen_out <= sync_in.overheat;
			pwr_state_out <= state_nxt;
		end
	end

endmodule : processor_sideband_control

// File: hdl/sideband_pkg.sv
package sideband_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int unsigned SENSOR_W = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	// warning lead before a global reset is carried out, in ns
	localparam int unsigned WARN_LEAD_NS = 1000;
	localparam int unsigned WARN_LEAD_CYC = (WARN_LEAD_NS * 50 + 999) / 1000;
	localparam logic [7:0] WARN_LEAD_CNT = 8'(WARN_LEAD_CYC);
	localparam logic [7:0] CNT_ZERO = 8'h00;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RST_OE_N = 1'b1;
	localparam logic RST_PLTRST_N = 1'b0;
	localparam logic RST_SYNC = 1'b0;

	// ----------------------------------------
	// platform power states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ON = 2'b01,
		ST_WARN = 2'b11,
		ST_S5 = 2'b10
	} pwr_state_t;

	typedef struct packed {
		logic overheat;
		logic wake;
		logic [SENSOR_W-1:0] sensor;
	} side_in_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drive_t;

endpackage : sideband_pkg

// File: hdl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule : sync2

// File: tb/cpu_side_model.sv
`timescale 1ns/100ps
module cpu_side_model (
	input wire logic clk_sys_in,
	input wire logic hot_in,
	input wire logic wake_in,
	input wire logic hub_bus_oe_n_in,
	input wire logic hub_bus_in,
	output logic trip_n_out,
	output logic wake_out,
	output logic bus_level_out
);
	logic last_r = 1'b0;
	assign trip_n_out = !hot_in;
	assign wake_out = wake_in;
	// no pull on this wire: once released it shows the opposite of the last driven level
	always @(negedge clk_sys_in) begin
		if (!hub_bus_oe_n_in) begin
			last_r <= hub_bus_in;
		end
	end
	assign bus_level_out = hub_bus_oe_n_in ? !last_r : hub_bus_in;
endmodule : cpu_side_model

// File: tb/sideband_sva.sv
`timescale 1ns/100ps
module sideband_sva (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic primary_power_ok_in,
	input wire logic global_reset_req_in,
	input wire logic deep_sleep_in,
	input wire logic overheat_trip_in_n,
	input wire logic cpu_wake_event_in,
	input wire logic [3:0] thermal_sensor_in,
	input wire logic cpu_power_good_out,
	input wire logic cpu_power_good_oe_n_out,
	input wire logic cpu_platform_reset_n_out,
	input wire logic cpu_platform_reset_oe_n_out,
	input wire logic pwr_mgmt_sync_out,
	input wire logic thermal_single_wire_bus_oe_n_out,
	input wire logic [1:0] pwr_state_out,
	input wire logic global_reset_go_out,
	input wire logic [3:0] thermal_sensor_out
);
	logic [7:0] warn_r;
	always_ff @(posedge clk_sys_in) begin
		warn_r <= (rst_in || !pwr_mgmt_sync_out) ? 8'h00 : warn_r + 8'h01;
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	property p_rst;
		$fell(rst_in) |-> cpu_power_good_oe_n_out && !cpu_platform_reset_n_out && !pwr_mgmt_sync_out
			&& thermal_single_wire_bus_oe_n_out ##1 thermal_single_wire_bus_oe_n_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset pin states");
	property p_drv;
		!rst_in |=> !cpu_power_good_oe_n_out && cpu_power_good_out == $past(primary_power_ok_in);
	endproperty
	a_drv: assert property (p_drv) else $error("power good");
	property p_plt;
		!rst_in |=> cpu_platform_reset_n_out && cpu_platform_reset_oe_n_out == $past(deep_sleep_in);
	endproperty
	a_plt: assert property (p_plt) else $error("platform reset");
	property p_trip;
		$fell(overheat_trip_in_n) ##1 !overheat_trip_in_n [*2] |=> pwr_state_out == sideband_pkg::ST_S5;
	endproperty
	a_trip: assert property (p_trip) else $error("overheat");
	property p_warn;
		global_reset_req_in && overheat_trip_in_n && pwr_state_out == sideband_pkg::ST_ON
			|=> pwr_mgmt_sync_out;
	endproperty
	a_warn: assert property (p_warn) else $error("sync start");
	property p_go;
		global_reset_go_out |-> warn_r == sideband_pkg::WARN_LEAD_CNT;
	endproperty
	a_go: assert property (p_go) else $error("warning span");
	property p_wake;
		$rose(cpu_wake_event_in) && overheat_trip_in_n && pwr_state_out == sideband_pkg::ST_S5
			##1 (cpu_wake_event_in && overheat_trip_in_n) [*2] |=> pwr_state_out == sideband_pkg::ST_ON;
	endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_sense;
		!rst_in [*4] |-> thermal_sensor_out == $past(thermal_sensor_in, 3);
	endproperty
	a_sense: assert property (p_sense) else $error("sensor");
	property p_bus;
		(pwr_state_out == sideband_pkg::ST_S5 || deep_sleep_in) |=> thermal_single_wire_bus_oe_n_out;
	endproperty
	a_bus: assert property (p_bus) else $error("bus released");
	c_go: cover property (global_reset_go_out);
	c_trip: cover property (!overheat_trip_in_n && pwr_state_out == sideband_pkg::ST_S5);
	c_sleep: cover property ($rose(cpu_platform_reset_oe_n_out));
endmodule : sideband_sva
bind processor_sideband_control sideband_sva chk_u (.*);

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic primary_power_ok_in = 1'b0;
	logic global_reset_req_in = 1'b0;
	logic deep_sleep_in = 1'b0;
	logic hot = 1'b0;
	logic wake = 1'b0;
	logic thermal_bus_tx_en_in = 1'b1;
	logic thermal_bus_tx_bit_in = 1'b1;
	logic [3:0] thermal_sensor_in = 4'h0;
	logic overheat_trip_in_n, cpu_wake_event_in, thermal_single_wire_bus_in, cpu_power_good_out;
	logic cpu_power_good_oe_n_out, cpu_platform_reset_n_out, cpu_platform_reset_oe_n_out;
	logic pwr_mgmt_sync_out, thermal_single_wire_bus_out, thermal_single_wire_bus_oe_n_out;
	logic global_reset_go_out, wake_seen_out, overheat_seen_out, thermal_bus_rx_out;
	logic [1:0] pwr_state_out;
	logic [3:0] thermal_sensor_out;
	int errors = 0;
	int checked = 0;
	always #10 clk_sys_in = !clk_sys_in;
	processor_sideband_control dut_u (.*);
	cpu_side_model cpu_u (.clk_sys_in(clk_sys_in), .hot_in(hot), .wake_in(wake),
		.hub_bus_oe_n_in(thermal_single_wire_bus_oe_n_out), .hub_bus_in(thermal_single_wire_bus_out),
		.trip_n_out(overheat_trip_in_n), .wake_out(cpu_wake_event_in),
		.bus_level_out(thermal_single_wire_bus_in));
	task automatic complete_run;
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : step
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
		checked++;
		if (v !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic st(input sideband_pkg::pwr_state_t e);
		chk("state", 8'(e), 8'(pwr_state_out));
	endtask : st
	task automatic t_power;
		primary_power_ok_in = 1'b1;
		step(3);
		chk("pgood", 8'h01, 8'({cpu_power_good_oe_n_out, cpu_power_good_out}));
		chk("pltrst_oe", 8'h00, 8'(cpu_platform_reset_oe_n_out));
		chk("pltrst", 8'h01, 8'(cpu_platform_reset_n_out));
		st(sideband_pkg::ST_ON);
	endtask : t_power
	task automatic t_warn;
		int n;
		n = 0;
		global_reset_req_in = 1'b1;
		step(1);
		global_reset_req_in = 1'b0;
		while (pwr_mgmt_sync_out === 1'b1 && n < 80) begin
			n++;
			step(1);
		end
		chk("warn", sideband_pkg::WARN_LEAD_CNT, 8'(n));
		chk("go", 8'h01, 8'(global_reset_go_out));
		st(sideband_pkg::ST_S5);
	endtask : t_warn
	task automatic t_wake;
		wake = 1'b1;
		step(4);
		st(sideband_pkg::ST_ON);
		chk("wake_seen", 8'h01, 8'(wake_seen_out));
		wake = 1'b0;
	endtask : t_wake
	task automatic t_trip;
		global_reset_req_in = 1'b1;
		step(1);
		global_reset_req_in = 1'b0;
		hot = 1'b1;
		step(4);
		st(sideband_pkg::ST_S5);
		chk("sync", 8'h00, 8'(pwr_mgmt_sync_out));
		chk("go", 8'h00, 8'(global_reset_go_out));
		chk("hot_seen", 8'h01, 8'(overheat_seen_out));
		wake = 1'b1;
		step(4);
		st(sideband_pkg::ST_S5);
		hot = 1'b0;
		step(5);
		st(sideband_pkg::ST_ON);
		wake = 1'b0;
	endtask : t_trip
	task automatic t_sleep;
		thermal_sensor_in = 4'ha;
		thermal_bus_tx_bit_in = 1'b0;
		step(3);
		chk("sensor", 8'h0a, 8'(thermal_sensor_out));
		chk("bus_oe", 8'h00, 8'(thermal_single_wire_bus_oe_n_out));
		chk("bus_out", 8'h00, 8'(thermal_single_wire_bus_out));
		chk("bus_rx", 8'h00, 8'(thermal_bus_rx_out));
		deep_sleep_in = 1'b1;
		step(3);
		chk("pltrst_oe", 8'h01, 8'(cpu_platform_reset_oe_n_out));
		chk("bus_oe", 8'h01, 8'(thermal_single_wire_bus_oe_n_out));
		chk("bus_rx", 8'h01, 8'(thermal_bus_rx_out));
	endtask : t_sleep
	task automatic t_reset;
		deep_sleep_in = 1'b0;
		rst_in = 1'b1;
		step(2);
		chk("pgood_oe", 8'h01, 8'(cpu_power_good_oe_n_out));
		chk("pltrst", 8'h00, 8'(cpu_platform_reset_n_out));
		chk("pltrst_oe", 8'h00, 8'(cpu_platform_reset_oe_n_out));
		chk("bus_oe", 8'h01, 8'(thermal_single_wire_bus_oe_n_out));
		chk("sync", 8'h00, 8'(pwr_mgmt_sync_out));
		rst_in = 1'b0;
		step(1);
		chk("pgood_oe", 8'h00, 8'(cpu_power_good_oe_n_out));
		chk("pltrst", 8'h01, 8'(cpu_platform_reset_n_out));
		chk("bus_oe", 8'h01, 8'(thermal_single_wire_bus_oe_n_out));
		step(1);
		chk("bus_oe", 8'h00, 8'(thermal_single_wire_bus_oe_n_out));
	endtask : t_reset
	initial begin
		step(12);
		rst_in = 1'b0;
		t_power();
		t_warn();
		t_wake();
		t_trip();
		t_sleep();
		t_reset();
		complete_run();
	end
	initial begin
		#20000;
		errors++;
		complete_run();
	end
endmodule : tb
